//--- design/rcsc_gear.v
// Clock gear: derives fast and divided system clock enables.
// Assumes clk is the high-frequency oscillator, lf_tick one fs pulse.
`timescale 1ns/1ps
`include "rcsc_regs.vh"

module rcsc_gear (
  clk,
  srst,
  hf_run,
  lf_tick,
  src_lf,
  gear,
  sys_tick
);
  input  wire       clk;
  input  wire       srst;
  input  wire       hf_run;
  input  wire       lf_tick;
  input  wire       src_lf;
  input  wire [2:0] gear;
  output reg        sys_tick;

  reg  [3:0] div_r;
  reg        half_r;
  reg        fph;

  ////////////////////////////////////////////////////////////////////
  // Gear picks fc/1..fc/16 as the fast clock, or fs alone
  always @* begin
    case (gear)
      3'h0:    fph = 1'b1;
      3'h1:    fph = div_r[0];
      3'h2:    fph = &div_r[1:0];
      3'h3:    fph = &div_r[2:0];
      default: fph = &div_r;
    endcase
    if (src_lf)
      fph = lf_tick;
    else if (!hf_run)
      fph = 1'b0;
  end

  // Divided clock is the fast clock halved: one tick is one state
  always @(posedge clk) begin
    if (srst) begin
      div_r    <= 4'h0;
      half_r   <= 1'b0;
      sys_tick <= 1'b0;
    end else begin
      if (hf_run)
        div_r <= div_r + 4'h1;
      sys_tick <= 1'b0;
      if (fph) begin
        half_r   <= ~half_r;
        sys_tick <= half_r;
      end
    end
  end
endmodule

//--- design/rcsc_regs.vh
// Constants of the reset and clock-state controller.
// Assumes inclusion by every rcsc design file; definitions only.
`ifndef RCSC_REGS_VH
`define RCSC_REGS_VH

// Values loaded when a reset is accepted, plus the gear limit and the boot vector address and byte count
`define RCSC_GEAR_RST      3'h4
`define RCSC_GEAR_MAX      3'h4
`define RCSC_SP_RST        32'h0000_0100
`define RCSC_IFF_RST       3'h7
`define RCSC_MAX_RST       1'h1
`define RCSC_RFP_RST       3'h0
`define RCSC_VEC_BASE      24'h00_8000
`define RCSC_VEC_BYTES     2'h3

// Least low time of the reset pin, in divided-clock periods
`define RCSC_RST_MIN_STATES 10

// Standby modes requested by software
`define RCSC_MODE_NORMAL   3'h0
`define RCSC_MODE_RUN      3'h1
`define RCSC_MODE_IDLE2    3'h2
`define RCSC_MODE_IDLE1    3'h3
`define RCSC_MODE_STOP     3'h4

// Boot sequencer states
`define RCSC_ST_HOLD       2'h0
`define RCSC_ST_READ       2'h1
`define RCSC_ST_RUN        2'h2

`endif

//--- design/rcsc_rfilt.v
// Reset pin filter: accepts reset after a minimum low time in states.
// Assumes reset_n_pin is synchronous to clk.
`timescale 1ns/1ps
`include "rcsc_regs.vh"

module rcsc_rfilt #(
  parameter MIN_STATES = `RCSC_RST_MIN_STATES
) (
  clk,
  srst,
  reset_n_pin,
  sys_tick,
  accepted
);
  input  wire clk;
  input  wire srst;
  input  wire reset_n_pin;
  input  wire sys_tick;
  output reg  accepted;

  reg [4:0] low_cnt_r;

  ////////////////////////////////////////////////////////////////////
  // Short glitches never reset the core; release is immediate
  always @(posedge clk) begin
    if (srst) begin
      low_cnt_r <= 5'h00;
      accepted  <= 1'b1;
    end else if (reset_n_pin) begin
      low_cnt_r <= 5'h00;
      accepted  <= 1'b0;
    end else if (sys_tick && !accepted) begin
      if (low_cnt_r == MIN_STATES[4:0] - 5'h01)
        accepted <= 1'b1;
      else
        low_cnt_r <= low_cnt_r + 5'h01;
    end
  end
endmodule

//--- design/rcsc_top.v
// Reset and clock-state control: boot vector load, core status
// defaults, pin states during reset, bus-width strap and standby.
// Assumes one 50 MHz clk standing for the high-frequency oscillator,
// inputs synchronous to clk, and a byte memory port with an ack.
`timescale 1ns/1ps
`include "rcsc_regs.vh"

// Functional notes
// - Reset sets gear to 1/16, so divided clock is fc/32.
// - Program counter loads bytes 8000H, 8001H, 8002H as low, mid, high.
// - System stack pointer is set to 100H on reset.
// - Interrupt mask level field becomes 111 on reset.
// - Maximum-mode status bit becomes 1 on reset.
// - Register bank pointer becomes 000 on reset.
// - Fetch starts at the vector; nothing else in the core changes.
// - Peripherals reset to defaults, every port pin in plain port mode.
// - Watchdog pin is 0 in reset; watchdog enabled once reset ends.
// - Clock output pin is pulled high in reset, not clocked.
// - Address latch enable is 0 without ROM, undriven with ROM.
// - ROM variant boots over internal 16-bit bus; width from settings.
// - ROM-less, strap 0: port 1 is muxed upper address/data.
// - ROM-less, strap 1: port 1 address only, bus fixed 8-bit.
// - Single mode uses high-frequency oscillator only; dual uses both.
// - Source bit and gear choose fast clock; divided tick is a state.
// - Divided clock is fc/2 to fc/32, or fs/2 in dual mode.
// - Dual run and idle keep the system oscillator running.
module rcsc_top #(
  parameter RST_MIN_STATES = `RCSC_RST_MIN_STATES
) (
  clk,
  srst,
  reset_n_pin,
  rom_variant,
  bus_width_strap,
  lf_osc_tick,
  dual_clock_mode,
  clock_source_select,
  clock_gear_field,
  gear_wr,
  hf_osc_sw_en,
  lf_osc_sw_en,
  mode_sel,
  mode_wr,
  wake,
  wdt_fire,
  ale_req,
  mem_rdata,
  mem_ack,
  mem_rd_r,
  mem_addr_r,
  pc_r,
  fetch_req_r,
  system_stack_pointer_r,
  interrupt_mask_level_r,
  max_mode_r,
  register_bank_pointer_r,
  core_reset_r,
  periph_reset_r,
  port_gpio_mode_r,
  watchdog_output_pin_r,
  watchdog_en_r,
  clk_out_r,
  clk_out_oe_r,
  clk_out_pullup_r,
  ale_r,
  ale_oe_r,
  internal_bus16_r,
  upper_addr_data_line_mux_r,
  port1_addr_only_r,
  bus_fixed8_r,
  port1_cfg_ignore_r,
  region_width_ignore_r,
  hf_osc_run_r,
  lf_osc_run_r,
  divided_tick_r,
  core_clk_en_r,
  periph_clk_en_r,
  adc_clk_en_r
);
  input  wire        clk;
  input  wire        srst;
  input  wire        reset_n_pin;
  input  wire        rom_variant;
  input  wire        bus_width_strap;
  input  wire        lf_osc_tick;
  input  wire        dual_clock_mode;
  input  wire        clock_source_select;
  input  wire [2:0]  clock_gear_field;
  input  wire        gear_wr;
  input  wire        hf_osc_sw_en;
  input  wire        lf_osc_sw_en;
  input  wire [2:0]  mode_sel;
  input  wire        mode_wr;
  input  wire        wake;
  input  wire        wdt_fire;
  input  wire        ale_req;
  input  wire [7:0]  mem_rdata;
  input  wire        mem_ack;
  output reg         mem_rd_r;
  output reg  [23:0] mem_addr_r;
  output reg  [23:0] pc_r;
  output reg         fetch_req_r;
  output reg  [31:0] system_stack_pointer_r;
  output reg  [2:0]  interrupt_mask_level_r;
  output reg         max_mode_r;
  output reg  [2:0]  register_bank_pointer_r;
  output reg         core_reset_r;
  output reg         periph_reset_r;
  output reg         port_gpio_mode_r;
  output reg         watchdog_output_pin_r;
  output reg         watchdog_en_r;
  output reg         clk_out_r;
  output reg         clk_out_oe_r;
  output reg         clk_out_pullup_r;
  output reg         ale_r;
  output reg         ale_oe_r;
  output reg         internal_bus16_r;
  output reg         upper_addr_data_line_mux_r;
  output reg         port1_addr_only_r;
  output reg         bus_fixed8_r;
  output reg         port1_cfg_ignore_r;
  output reg         region_width_ignore_r;
  output reg         hf_osc_run_r;
  output reg         lf_osc_run_r;
  output reg         divided_tick_r;
  output reg         core_clk_en_r;
  output reg         periph_clk_en_r;
  output reg         adc_clk_en_r;

  reg  [1:0] st_r;
  reg  [1:0] byte_r;
  reg  [2:0] gear_r;
  reg        src_lf_r;
  reg  [2:0] mode_r;
  reg        hf_nxt;
  reg        lf_nxt;
  wire       sys_tick;
  wire       in_reset;
  wire       src_lf_eff;

  ////////////////////////////////////////////////////////////////////
  // Reset acceptance and divided clock
  rcsc_rfilt #(
    .MIN_STATES  (RST_MIN_STATES)
  ) u_rfilt (
    .clk         (clk),
    .srst        (srst),
    .reset_n_pin (reset_n_pin),
    .sys_tick    (sys_tick),
    .accepted    (in_reset)
  );

  // Low oscillator only counts as a source in dual mode
  assign src_lf_eff = src_lf_r & dual_clock_mode;

  rcsc_gear u_gear (
    .clk      (clk),
    .srst     (srst),
    .hf_run   (hf_nxt),
    .lf_tick  (lf_osc_tick & lf_nxt),
    .src_lf   (src_lf_eff),
    .gear     (gear_r),
    .sys_tick (sys_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // Clock source, gear and standby mode
  always @(posedge clk) begin
    if (srst || in_reset) begin
      gear_r   <= `RCSC_GEAR_RST;
      src_lf_r <= 1'b0;
      mode_r   <= `RCSC_MODE_NORMAL;
    end else begin
      // Reserved gear codes are dropped rather than guessed at
      if (gear_wr && clock_gear_field <= `RCSC_GEAR_MAX) begin
        gear_r   <= clock_gear_field;
        src_lf_r <= clock_source_select;
      end
      if (wake)
        mode_r <= `RCSC_MODE_NORMAL;
      else if (mode_wr && st_r == `RCSC_ST_RUN)
        mode_r <= mode_sel;
    end
  end

  // Oscillator enables; the one feeding the system clock stays on except in STOP
  always @* begin
    if (in_reset) begin
      hf_nxt = 1'b1;
      lf_nxt = 1'b0;
    end else if (mode_r == `RCSC_MODE_STOP) begin
      hf_nxt = 1'b0;
      lf_nxt = 1'b0;
    end else if (!dual_clock_mode) begin
      hf_nxt = 1'b1;
      lf_nxt = 1'b0;
    end else begin
      hf_nxt = src_lf_r ? hf_osc_sw_en : 1'b1;
      lf_nxt = src_lf_r ? 1'b1 : lf_osc_sw_en;
    end
  end

  // Per-mode clock gating of core, peripherals and converter
  always @(posedge clk) begin
    if (srst) begin
      hf_osc_run_r    <= 1'b1;
      lf_osc_run_r    <= 1'b0;
      divided_tick_r  <= 1'b0;
      core_clk_en_r   <= 1'b0;
      periph_clk_en_r <= 1'b0;
      adc_clk_en_r    <= 1'b0;
    end else begin
      hf_osc_run_r   <= hf_nxt;
      lf_osc_run_r   <= lf_nxt;
      divided_tick_r <= sys_tick;
      core_clk_en_r  <= sys_tick && st_r == `RCSC_ST_RUN &&
                        mode_r == `RCSC_MODE_NORMAL;
      periph_clk_en_r <= sys_tick && !in_reset &&
                         (mode_r == `RCSC_MODE_NORMAL ||
                          mode_r == `RCSC_MODE_RUN ||
                          mode_r == `RCSC_MODE_IDLE2);
      adc_clk_en_r <= sys_tick && !in_reset &&
                      (mode_r == `RCSC_MODE_NORMAL ||
                       mode_r == `RCSC_MODE_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Boot sequencer: hold, read three vector bytes, then run
  always @(posedge clk) begin
    if (srst) begin
      st_r        <= `RCSC_ST_HOLD;
      byte_r      <= 2'h0;
      mem_rd_r    <= 1'b0;
      mem_addr_r  <= 24'h00_0000;
      pc_r        <= 24'h00_0000;
      fetch_req_r <= 1'b0;
    end else begin
      fetch_req_r <= 1'b0;
      if (in_reset) begin
        st_r     <= `RCSC_ST_HOLD;
        byte_r   <= 2'h0;
        mem_rd_r <= 1'b0;
      end else begin
        case (st_r)
          `RCSC_ST_HOLD: begin
            st_r       <= `RCSC_ST_READ;
            mem_rd_r   <= 1'b1;
            mem_addr_r <= `RCSC_VEC_BASE;
          end
          `RCSC_ST_READ: begin
            if (mem_ack) begin
              case (byte_r)
                2'h0:    pc_r[7:0]   <= mem_rdata;
                2'h1:    pc_r[15:8]  <= mem_rdata;
                default: pc_r[23:16] <= mem_rdata;
              endcase
              if (byte_r == `RCSC_VEC_BYTES - 2'h1) begin
                mem_rd_r    <= 1'b0;
                st_r        <= `RCSC_ST_RUN;
                fetch_req_r <= 1'b1;
              end else begin
                byte_r     <= byte_r + 2'h1;
                mem_addr_r <= mem_addr_r + 24'h00_0001;
              end
            end
          end
          `RCSC_ST_RUN: begin
            st_r <= `RCSC_ST_RUN;
          end
          default: begin
            st_r <= `RCSC_ST_HOLD;
          end
        endcase
      end
    end
  end

  // Only these core fields are touched; RAM and others keep values
  always @(posedge clk) begin
    if (srst || in_reset) begin
      system_stack_pointer_r  <= `RCSC_SP_RST;
      interrupt_mask_level_r  <= `RCSC_IFF_RST;
      max_mode_r              <= `RCSC_MAX_RST;
      register_bank_pointer_r <= `RCSC_RFP_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin states during and after reset
  always @(posedge clk) begin
    if (srst) begin
      core_reset_r          <= 1'b1;
      periph_reset_r        <= 1'b1;
      port_gpio_mode_r      <= 1'b1;
      watchdog_output_pin_r <= 1'b0;
      watchdog_en_r         <= 1'b1;
      clk_out_r             <= 1'b1;
      clk_out_oe_r          <= 1'b0;
      clk_out_pullup_r      <= 1'b1;
      ale_r                 <= 1'b0;
      // Block reset is a reset too: ALE driven low only without ROM
      ale_oe_r              <= ~rom_variant;
    end else begin
      core_reset_r   <= st_r != `RCSC_ST_RUN;
      periph_reset_r <= in_reset;
      if (in_reset) begin
        port_gpio_mode_r      <= 1'b1;
        watchdog_output_pin_r <= 1'b0;
        watchdog_en_r         <= 1'b1;
        clk_out_r             <= 1'b1;
        clk_out_oe_r          <= 1'b0;
        clk_out_pullup_r      <= 1'b1;
        ale_r                 <= 1'b0;
        ale_oe_r              <= ~rom_variant;
      end else begin
        port_gpio_mode_r      <= 1'b0;
        watchdog_output_pin_r <= wdt_fire;
        clk_out_oe_r          <= 1'b1;
        clk_out_pullup_r      <= 1'b0;
        // Pin shows the divided clock halved
        if (sys_tick)
          clk_out_r <= ~clk_out_r;
        ale_r    <= ale_req;
        ale_oe_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus width strap, caught while reset is held
  always @(posedge clk) begin
    if (srst) begin
      internal_bus16_r           <= 1'b0;
      upper_addr_data_line_mux_r <= 1'b0;
      port1_addr_only_r          <= 1'b0;
      bus_fixed8_r               <= 1'b0;
      port1_cfg_ignore_r         <= 1'b0;
      region_width_ignore_r      <= 1'b0;
    end else if (in_reset) begin
      internal_bus16_r <= rom_variant;
      upper_addr_data_line_mux_r <= ~rom_variant & ~bus_width_strap;
      port1_addr_only_r  <= ~rom_variant & bus_width_strap;
      bus_fixed8_r       <= ~rom_variant & bus_width_strap;
      port1_cfg_ignore_r <= ~rom_variant;
      // Program region width ignored when ROM-less strap 1 fixes the 8-bit bus
      region_width_ignore_r <= ~rom_variant & bus_width_strap;
    end
  end
endmodule

//--- sim/rcsc_mem_model.sv
// Boot memory model: serves the vector bytes with an ack.
// Assumes the bench sets the vector and wait before each boot.
`timescale 1ns/1ps
module rcsc_mem_model (
  input  logic        clk,
  input  logic        mem_rd_r,
  input  logic [23:0] mem_addr_r,
  input  logic [23:0] vec,
  input  logic [3:0]  wait_n,
  output logic [7:0]  mem_rdata,
  output logic        mem_ack
);
  logic [3:0] cnt_r;
  logic [7:0] last_r = 8'h00;
  // Zero wait gives back-to-back acks, larger waits stall the boot
  assign mem_ack = mem_rd_r && (cnt_r >= wait_n);
  always @* begin
    case (mem_addr_r)
      24'h00_8000: mem_rdata = vec[7:0];
      24'h00_8001: mem_rdata = vec[15:8];
      24'h00_8002: mem_rdata = vec[23:16];
      default:     mem_rdata = ~last_r;
    endcase
    // A released bus shows a value that changes every cycle
    if (!mem_ack)
      mem_rdata = ~last_r;
  end
  always @(posedge clk) begin
    last_r <= mem_rdata;
    if (!mem_rd_r || mem_ack)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end
endmodule

//--- sim/rcsc_props.sv
// Assertions on the rcsc_top ports.
// Assumes a bind onto rcsc_top, ports matched by name.
`timescale 1ns/1ps
module rcsc_props #(
  parameter RST_MIN_STATES = 10
) (
  input logic        clk, srst, rom_variant, mem_ack, mode_wr, wake,
  input logic        gear_wr, mem_rd_r, fetch_req_r, core_reset_r,
  input logic        periph_reset_r, watchdog_output_pin_r, clk_out_r,
  input logic        clk_out_oe_r, clk_out_pullup_r, ale_r, ale_oe_r,
  input logic        max_mode_r, hf_osc_run_r, lf_osc_run_r,
  input logic        divided_tick_r, core_clk_en_r, periph_clk_en_r,
  input logic        adc_clk_en_r,
  input logic [2:0]  mode_sel, interrupt_mask_level_r,
  input logic [2:0]  register_bank_pointer_r,
  input logic [23:0] mem_addr_r,
  input logic [31:0] system_stack_pointer_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Tick gaps are judged only once a phase is known and no write seen
  logic [5:0] gap_r;
  logic       primed_r;
  logic       cfg_chg_r;
  always @(posedge clk) begin
    if (srst) begin
      gap_r     <= 6'h00;
      primed_r  <= 1'b0;
      cfg_chg_r <= 1'b0;
    end else begin
      if (divided_tick_r)
        gap_r <= 6'h00;
      else if (gap_r != 6'h3F)
        gap_r <= gap_r + 6'h01;
      if (divided_tick_r)
        primed_r <= 1'b1;
      if (gear_wr || mode_wr)
        cfg_chg_r <= 1'b1;
    end
  end
  ////////////////////////////////////////
  sp_reset_a: assert property (core_reset_r |->
    system_stack_pointer_r == 32'h0000_0100) else $error("sp value");
  status_reset_a: assert property (core_reset_r |->
    interrupt_mask_level_r == 3'h7 && max_mode_r &&
    register_bank_pointer_r == 3'h0) else $error("status value");
  wdt_low_a: assert property (periph_reset_r |->
    !watchdog_output_pin_r) else $error("watchdog pin");
  clk_pullup_a: assert property (periph_reset_r |->
    clk_out_r && !clk_out_oe_r && clk_out_pullup_r) else $error("clk pin");
  ale_reset_a: assert property (periph_reset_r |->
    !ale_r && ale_oe_r == !$past(rom_variant)) else $error("ale pin");
  tick_rate_a: assert property (
    divided_tick_r && primed_r && !cfg_chg_r |-> gap_r == 6'h1F)
    else $error("reset tick gap");
  vec_first_a: assert property ($rose(mem_rd_r) |->
    mem_addr_r == 24'h00_8000) else $error("first vector address");
  vec_step_a: assert property (mem_rd_r && mem_ack |=>
    !mem_rd_r || mem_addr_r == $past(mem_addr_r) + 24'h00_0001)
    else $error("vector address step");
  fetch_run_a: assert property (fetch_req_r |->
    $past(mem_ack) && !mem_rd_r ##1 !core_reset_r) else $error("fetch");
  stop_halt_a: assert property (
    mode_wr && mode_sel == 3'h4 && !wake && !core_reset_r |-> ##3
    (!hf_osc_run_r && !lf_osc_run_r && !core_clk_en_r &&
     !periph_clk_en_r && !divided_tick_r)[*4]) else $error("stop mode");
  idle1_halt_a: assert property (
    mode_wr && mode_sel == 3'h3 && !wake && !core_reset_r |-> ##3
    (!core_clk_en_r && !periph_clk_en_r)[*4]) else $error("idle1 mode");
  idle2_adc_a: assert property (
    mode_wr && mode_sel == 3'h2 && !wake && !core_reset_r |-> ##3
    (!adc_clk_en_r && !core_clk_en_r)[*4]) else $error("idle2 mode");
endmodule

//--- sim/rcsc_top_tb.sv
// Bench for rcsc_top: boot rows, pin reset, gears and modes.
// Assumes rcsc_props and rcsc_mem_model are compiled first.
`timescale 1ns/1ps
module rcsc_top_tb;
  localparam MINS = 2;
  logic        clk, srst, reset_n_pin, rom_variant, bus_width_strap;
  logic        lf_osc_tick, dual_clock_mode, clock_source_select, gear_wr;
  logic        hf_osc_sw_en, lf_osc_sw_en, mode_wr, wake, wdt_fire;
  logic        ale_req, mem_ack, mem_rd_r, fetch_req_r, max_mode_r;
  logic        core_reset_r, periph_reset_r, port_gpio_mode_r, clk_out_r;
  logic        watchdog_output_pin_r, watchdog_en_r, clk_out_oe_r;
  logic        clk_out_pullup_r, ale_r, ale_oe_r, internal_bus16_r;
  logic        upper_addr_data_line_mux_r, port1_addr_only_r;
  logic        bus_fixed8_r, port1_cfg_ignore_r, region_width_ignore_r;
  logic        hf_osc_run_r, lf_osc_run_r, divided_tick_r, core_clk_en_r;
  logic        periph_clk_en_r, adc_clk_en_r;
  logic [2:0]  clock_gear_field, mode_sel, interrupt_mask_level_r;
  logic [2:0]  register_bank_pointer_r;
  logic [3:0]  wait_n;
  logic [7:0]  mem_rdata;
  logic [23:0] mem_addr_r, pc_r, vec;
  logic [31:0] system_stack_pointer_r;
  int          num_errors, check_count, n;
  typedef struct packed {
    logic        rv;
    logic        st;
    logic [3:0]  w;
    logic [23:0] v;
    logic [5:0]  ex;
  } rcsc_row_t;
  // Variant, strap, memory wait, vector, expected bus-mode flags
  rcsc_row_t rows [3] = '{
    '{1'b1, 1'b1, 4'h0, 24'h12_3456, 6'h20},
    '{1'b0, 1'b0, 4'h3, 24'hA5_5AC3, 6'h12},
    '{1'b0, 1'b1, 4'h1, 24'hFF_0102, 6'h0F}};
  rcsc_top #(.RST_MIN_STATES(MINS)) rcsc_top_inst (.*);
  rcsc_mem_model rcsc_mem_model_inst (.*);
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Low-frequency oscillator stand-in: one pulse every 10 clocks
  initial begin
    lf_osc_tick = 1'b0;
    forever begin
      repeat (9) @(negedge clk);
      lf_osc_tick = 1'b1;
      @(negedge clk);
      lf_osc_tick = 1'b0;
    end
  end
  task automatic chk(input string nm, input logic [47:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_for(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      chk("timeout", 1, 0);
      report_and_stop;
    end
  endtask
  task automatic tick_gap(input int exp);
    wait_for(divided_tick_r);
    @(negedge clk);
    n = 1;
    while (divided_tick_r !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("tick_gap", n, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // The wait lets the old divider phase die out before measuring
  task automatic set_gear(input logic [2:0] g, input logic src);
    clock_gear_field = g;
    clock_source_select = src;
    pulse(gear_wr);
    repeat (40) @(negedge clk);
  endtask
  task automatic set_mode(input logic [2:0] m);
    mode_sel = m;
    pulse(mode_wr);
    repeat (6) @(negedge clk);
  endtask
  task automatic boot(input rcsc_row_t r, input logic pin);
    rom_variant = r.rv;
    bus_width_strap = r.st;
    vec = r.v;
    wait_n = r.w;
    if (pin)
      reset_n_pin = 1'b0;
    else
      srst = 1'b1;
    repeat (pin ? 100 : 10) @(negedge clk);
    chk("core", {system_stack_pointer_r, interrupt_mask_level_r, max_mode_r,
        register_bank_pointer_r}, 39'h00_0000_8078);
    chk("pins", {watchdog_output_pin_r, clk_out_r, clk_out_oe_r,
        clk_out_pullup_r, ale_r, ale_oe_r, port_gpio_mode_r,
        periph_reset_r}, {5'h0A, ~r.rv, 2'h3});
    srst = 1'b0;
    reset_n_pin = 1'b1;
    wait_for(fetch_req_r);
    chk("pc", pc_r, r.v);
    @(negedge clk);
    chk("core_run", core_reset_r, 1'b0);
    chk("wdt_en", watchdog_en_r, 1'b1);
  endtask
  ////////////////////////////////////////
  initial begin
    {srst, reset_n_pin, wdt_fire, ale_req} = 4'hF;
    {rom_variant, bus_width_strap, dual_clock_mode} = 3'h0;
    {clock_source_select, gear_wr, mode_wr, wake} = 4'h0;
    {hf_osc_sw_en, lf_osc_sw_en} = 2'h0;
    {clock_gear_field, mode_sel, wait_n, vec} = 34'h0_0000_0000;
    num_errors = 0;
    check_count = 0;
    @(negedge clk);
    foreach (rows[i]) begin
      boot(rows[i], 1'b0);
      chk("strap", {internal_bus16_r, upper_addr_data_line_mux_r,
          port1_addr_only_r, bus_fixed8_r, port1_cfg_ignore_r,
          region_width_ignore_r}, rows[i].ex);
    end
    tick_gap(32);
    // A low pulse shorter than the minimum must not reset the core
    reset_n_pin = 1'b0;
    repeat (20) @(negedge clk);
    reset_n_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk("short_pulse", core_reset_r, 1'b0);
    for (int g = 0; g < 6; g++) begin
      set_gear(g == 5 ? 3'h7 : 3'(g), 1'b0);
      tick_gap(g == 5 ? 32 : 2 << g);
    end
    dual_clock_mode = 1'b1;
    set_gear(3'h4, 1'b1);
    tick_gap(20);
    set_mode(3'h3);
    chk("osc_idle", {hf_osc_run_r, lf_osc_run_r}, 2'h1);
    pulse(wake);
    hf_osc_sw_en = 1'b1;
    set_gear(3'h4, 1'b0);
    dual_clock_mode = 1'b0;
    for (int m = 1; m < 5; m++) begin
      set_mode(3'(m));
      chk("osc_mode", {hf_osc_run_r, lf_osc_run_r}, {m != 4, 1'b0});
      pulse(wake);
      repeat (6) @(negedge clk);
      chk("osc_wake", hf_osc_run_r, 1'b1);
    end
    set_gear(3'h0, 1'b0);
    boot(rows[0], 1'b1);
    tick_gap(32);
    report_and_stop;
  end
endmodule
bind rcsc_top rcsc_props #(.RST_MIN_STATES(RST_MIN_STATES))
  rcsc_props_inst (.*);
